// ### inc/tcv_pkg.sv
// Package of constants and state types for the timer compare value block
// Notes on behaviour
// - Each of the six channels keeps a 16-bit compare value and checks it against its timer count on every timer tick.
// - A detected match on a channel can raise that channel's output compare interrupt request.
// - A detected match on a channel can update the waveform driven on that channel's compare output pin.
// - Both bytes of a compare value change in one step, the upper byte waiting in an 8-bit holding register.
// - One upper-byte holding register serves every compare value and every other 16-bit register of both timers.
// - After software writes a counter, no channel of that timer matches on the next timer tick.
// - A channel's match flag is set in the timer cycle after the count equals the compare value.
package tcv_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int TCV_NCH = 6;
	localparam int TCV_NTIM = 2;
	localparam int TCV_CH_PER_TIM = 3;
	localparam int TCV_VAL_W = 16;
	localparam int TCV_ADDR_W = 8;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] TCV_OFF_CMP_LIMIT = 8'h30;
	localparam logic [7:0] TCV_OFF_CNT1_HI = 8'h30;
	localparam logic [7:0] TCV_OFF_CNT1_LO = 8'h34;
	localparam logic [7:0] TCV_OFF_CNT3_HI = 8'h38;
	localparam logic [7:0] TCV_OFF_CNT3_LO = 8'h3C;
	localparam logic [7:0] TCV_OFF_FLAG = 8'h40;
	localparam logic [7:0] TCV_OFF_IRQ_EN = 8'h44;
	localparam logic [7:0] TCV_OFF_PIN_MODE = 8'h48;
	// Compare value of channel n: high byte at 8*n, low byte at 8*n+4
	localparam int TCV_CH_SEL_LSB = 3;
	localparam int TCV_LO_SEL_BIT = 2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] TCV_CMP_RESET = 16'h0000;
	localparam logic [7:0] TCV_TEMP_RESET = 8'h00;
	localparam logic [5:0] TCV_IRQ_EN_RESET = 6'h00;
	localparam logic [11:0] TCV_PIN_MODE_RESET = 12'h000;

	// ----------------------------------------
	// Output pin action on match
	// ----------------------------------------
	typedef enum logic [1:0] {
		TCV_PIN_HOLD,
		TCV_PIN_TOGGLE,
		TCV_PIN_CLEAR,
		TCV_PIN_SET
	} tcv_pin_mode_type;

	// ----------------------------------------
	// State records
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] value;
		logic hit;
		logic flag;
		logic irq;
		logic pin;
	} tcv_chan_state_type;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [7:0] temp;
		logic [1:0] blockPend;
		logic [5:0] irqEnable;
		logic [11:0] pinMode;
		logic [1:0] countLoad;
		logic [15:0] countLoadValue;
	} tcv_state_type;
endpackage

// ### hw/tcv_compare_chan.sv
// One compare channel: value, equality, match flag, request and pin
`timescale 1ns/100ps
module tcv_compare_chan (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic valueWrite, // Commit a new compare value
	input wire logic [15:0] valueIn, // Value to commit
	input wire logic [15:0] timerCount, // Count of this channel's timer
	input wire logic timerTick, // Timer clock tick
	input wire logic matchBlock, // Suppress match on this tick
	input wire logic flagClear, // Clear the match flag
	input wire logic irqEnable, // Interrupt request enable
	input wire tcv_pkg::tcv_pin_mode_type pinMode, // Pin action on match
	output logic [15:0] value, // Current compare value
	output logic matchFlag, // Sticky match flag
	output logic irqReq, // Interrupt request
	output logic pinOut // Compare output pin
);
	import tcv_pkg::*;

	tcv_chan_state_type st_r;
	tcv_chan_state_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (valueWrite) begin
			st_nxt.value = valueIn;
		end
		st_nxt.hit = timerTick && (timerCount == st_r.value) && !matchBlock;
		st_nxt.flag = st_r.hit || (st_r.flag && !flagClear);
		st_nxt.irq = st_nxt.flag && irqEnable;
		if (st_r.hit) begin
			unique case (pinMode)
				TCV_PIN_HOLD: st_nxt.pin = st_r.pin;
				TCV_PIN_TOGGLE: st_nxt.pin = !st_r.pin;
				TCV_PIN_CLEAR: st_nxt.pin = 1'b0;
				TCV_PIN_SET: st_nxt.pin = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r <= '{value: TCV_CMP_RESET, hit: 1'b0, flag: 1'b0, irq: 1'b0, pin: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign value = st_r.value;
	assign matchFlag = st_r.flag;
	assign irqReq = st_r.irq;
	assign pinOut = st_r.pin;
endmodule

// ### hw/tcv_compare_regs.sv
// Compare value registers of two 16-bit timers with APB access
`timescale 1ns/100ps
module tcv_compare_regs (
	input wire logic clk_sys, // System clock, 250 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction, high for write
	input wire logic [tcv_pkg::TCV_ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic pready, // APB ready
	output logic [31:0] prdata, // APB read data
	output logic pslverr, // APB error, unmapped address
	input wire logic [15:0] timer1Count, // Timer 1 count
	input wire logic [15:0] timer3Count, // Timer 3 count
	input wire logic [1:0] timerTick, // Timer clock ticks, bit 0 timer 1
	output logic [1:0] countLoad, // Counter load strobes, bit 0 timer 1
	output logic [15:0] countLoadValue, // Value for the counter load
	output logic [5:0] compareMatchFlag, // Match flags, A B C of timer 1 then 3
	output logic [5:0] compareIrq, // Output compare interrupt requests
	output logic [5:0] compareOutputPin // Compare output pins
);
	import tcv_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	tcv_state_type st_r;
	tcv_state_type st_nxt;

	logic [15:0] chanValue [TCV_NCH];
	logic [5:0] valueWrite;
	logic [5:0] flagClear;
	logic [5:0] chanFlag;
	logic [5:0] chanIrq;
	logic [5:0] chanPin;
	logic apbTaken;
	logic apbAnswer;
	logic isCmp;
	logic isLo;
	logic [2:0] chSel;
	logic mapped;
	logic [31:0] readData;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	always_comb begin
		apbTaken = psel && penable && st_r.pready;
		apbAnswer = psel && penable && !st_r.pready;
		isCmp = paddr < TCV_OFF_CMP_LIMIT;
		isLo = paddr[TCV_LO_SEL_BIT];
		chSel = paddr[TCV_CH_SEL_LSB +: 3];
		mapped = 1'b0;
		if (paddr[1:0] == 2'b00) begin
			mapped = isCmp || paddr == TCV_OFF_CNT1_HI || paddr == TCV_OFF_CNT1_LO
				|| paddr == TCV_OFF_CNT3_HI || paddr == TCV_OFF_CNT3_LO
				|| paddr == TCV_OFF_FLAG || paddr == TCV_OFF_IRQ_EN
				|| paddr == TCV_OFF_PIN_MODE;
		end
	end

	// ----------------------------------------
	// Read multiplexer
	// ----------------------------------------
	always_comb begin
		readData = 32'h00000000;
		if (isCmp) begin
			if (isLo) begin
				readData = {24'h000000, chanValue[chSel][7:0]};
			end else begin
				readData = {24'h000000, chanValue[chSel][15:8]};
			end
		end else begin
			unique case (paddr)
				TCV_OFF_CNT1_HI: readData = {24'h000000, st_r.temp};
				TCV_OFF_CNT3_HI: readData = {24'h000000, st_r.temp};
				TCV_OFF_CNT1_LO: readData = {24'h000000, timer1Count[7:0]};
				TCV_OFF_CNT3_LO: readData = {24'h000000, timer3Count[7:0]};
				TCV_OFF_FLAG: readData = {26'h0, chanFlag};
				TCV_OFF_IRQ_EN: readData = {26'h0, st_r.irqEnable};
				TCV_OFF_PIN_MODE: readData = {20'h00000, st_r.pinMode};
				default: readData = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// Register file and bus answer
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		valueWrite = 6'h00;
		flagClear = 6'h00;
		st_nxt.countLoad = 2'b00;
		st_nxt.pready = apbAnswer;
		if (apbAnswer) begin
			st_nxt.pslverr = !mapped;
			st_nxt.prdata = pwrite ? 32'h00000000 : readData;
			// Reading a counter low byte parks its high byte for the next read
			if (!pwrite && mapped && paddr == TCV_OFF_CNT1_LO) begin
				st_nxt.temp = timer1Count[15:8];
			end
			if (!pwrite && mapped && paddr == TCV_OFF_CNT3_LO) begin
				st_nxt.temp = timer3Count[15:8];
			end
		end
		if (apbTaken && pwrite && mapped) begin
			if (isCmp) begin
				if (isLo) begin
					valueWrite[chSel] = 1'b1;
				end else begin
					st_nxt.temp = pwdata[7:0];
				end
			end else begin
				unique case (paddr)
					TCV_OFF_CNT1_HI: st_nxt.temp = pwdata[7:0];
					TCV_OFF_CNT3_HI: st_nxt.temp = pwdata[7:0];
					TCV_OFF_CNT1_LO: begin
						st_nxt.countLoad[0] = 1'b1;
						st_nxt.countLoadValue = {st_r.temp, pwdata[7:0]};
					end
					TCV_OFF_CNT3_LO: begin
						st_nxt.countLoad[1] = 1'b1;
						st_nxt.countLoadValue = {st_r.temp, pwdata[7:0]};
					end
					TCV_OFF_FLAG: flagClear = pwdata[5:0];
					TCV_OFF_IRQ_EN: st_nxt.irqEnable = pwdata[5:0];
					TCV_OFF_PIN_MODE: st_nxt.pinMode = pwdata[11:0];
					default: st_nxt.pinMode = st_r.pinMode;
				endcase
			end
		end
		// Match block: cleared by the tick it suppresses, a new counter write wins
		for (int t = 0; t < TCV_NTIM; t++) begin
			if (timerTick[t]) begin
				st_nxt.blockPend[t] = 1'b0;
			end
			if (st_nxt.countLoad[t]) begin
				st_nxt.blockPend[t] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000,
				temp: TCV_TEMP_RESET, blockPend: 2'b00, irqEnable: TCV_IRQ_EN_RESET,
				pinMode: TCV_PIN_MODE_RESET, countLoad: 2'b00, countLoadValue: 16'h0000};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Compare channels
	// ----------------------------------------
	for (genvar i = 0; i < TCV_NCH; i++) begin : gChan
		localparam int TIM = i / TCV_CH_PER_TIM;
		tcv_compare_chan uChan (
			.clk_sys(clk_sys),
			.rst(rst),
			.valueWrite(valueWrite[i]),
			.valueIn({st_r.temp, pwdata[7:0]}),
			.timerCount(TIM == 0 ? timer1Count : timer3Count),
			.timerTick(timerTick[TIM]),
			.matchBlock(st_r.blockPend[TIM]),
			.flagClear(flagClear[i]),
			.irqEnable(st_r.irqEnable[i]),
			.pinMode(tcv_pin_mode_type'(st_r.pinMode[2*i +: 2])),
			.value(chanValue[i]),
			.matchFlag(chanFlag[i]),
			.irqReq(chanIrq[i]),
			.pinOut(chanPin[i])
		);
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pready = st_r.pready;
	assign prdata = st_r.prdata;
	assign pslverr = st_r.pslverr;
	assign countLoad = st_r.countLoad;
	assign countLoadValue = st_r.countLoadValue;
	assign compareMatchFlag = chanFlag;
	assign compareIrq = chanIrq;
	assign compareOutputPin = chanPin;
endmodule

// ### dv/tcv_compare_monitor.sv
// Checker of match timing and counter load seen at the block ports
`timescale 1ns/100ps
module tcv_compare_monitor (
	input wire logic clk_sys, // Clock
	input wire logic rst, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [7:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic pready, // Ready
	input wire logic [1:0] timerTick, // Ticks
	input wire logic [1:0] countLoad, // Load strobes
	input wire logic [15:0] countLoadValue, // Load value
	input wire logic [5:0] compareMatchFlag, // Flags
	input wire logic [5:0] compareIrq, // Requests
	input wire logic [5:0] compareOutputPin // Pins
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	flag1_rise_a: assert property ((compareMatchFlag[2:0] & ~$past(compareMatchFlag[2:0])) != 3'h0
		|-> $past(timerTick[0], 2)) else $error("timer 1 flag rose without tick");
	flag3_rise_a: assert property ((compareMatchFlag[5:3] & ~$past(compareMatchFlag[5:3])) != 3'h0
		|-> $past(timerTick[1], 2)) else $error("timer 3 flag rose without tick");
	irq_needs_flag_a: assert property ((compareIrq & ~compareMatchFlag) == 6'h00)
		else $error("request without flag");
	pin1_move_a: assert property (compareOutputPin[2:0] != $past(compareOutputPin[2:0])
		|-> $past(timerTick[0], 2)) else $error("timer 1 pin moved without tick");
	pin3_move_a: assert property (compareOutputPin[5:3] != $past(compareOutputPin[5:3])
		|-> $past(timerTick[1], 2)) else $error("timer 3 pin moved without tick");
	load_cause_a: assert property (countLoad[0]
		|-> $past(psel && penable && pready && pwrite && paddr == 8'h34))
		else $error("load without counter write");
	load_low_a: assert property (countLoad[0]
		|-> countLoadValue[7:0] == $past(pwdata[7:0])) else $error("load low byte wrong");
	block_tick_a: assert property (countLoad[0] && timerTick[0]
		|-> ##2 (compareMatchFlag[2:0] & ~$past(compareMatchFlag[2:0])) == 3'h0)
		else $error("match not blocked");
endmodule
bind tcv_compare_regs tcv_compare_monitor mon (.clk_sys, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .timerTick, .countLoad, .countLoadValue, .compareMatchFlag,
	.compareIrq, .compareOutputPin);

// ### dv/tb.sv
// Bench for the compare value registers
`timescale 1ns/100ps
module tb;
	logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [15:0] t1 = 0, t3 = 0, clv;
	logic [1:0] tick = 0, cl;
	logic [5:0] flg, irq, pin;
	int err_count = 0, num_checks = 0;
	always #2 clk_sys = ~clk_sys;
	tcv_compare_regs DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .timer1Count(t1), .timer3Count(t3), .timerTick(tick),
		.countLoad(cl), .countLoadValue(clv), .compareMatchFlag(flg), .compareIrq(irq),
		.compareOutputPin(pin));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task end_sim;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			err_count++;
			$display("unexpected %s exp %h got %h", n, x, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		for (i = 0; i < 20 && pready !== 1'b1; i++)
			@(posedge clk_sys);
		if (i == 20) begin
			err_count++;
			end_sim;
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(0, a, 0);
		chk("prdata", x, r);
	endtask
	task tk(input int t, input logic [5:0] fx, input logic [5:0] px);
		logic [5:0] f0;
		@(posedge clk_sys);
		f0 = flg;
		tick[t] <= 1'b1;
		@(posedge clk_sys);
		tick <= 2'b00;
		@(posedge clk_sys);
		chk("early flag", 32'(f0), 32'(flg));
		@(posedge clk_sys);
		chk("flag", 32'(fx), 32'(flg));
		chk("irq", 32'(fx), 32'(irq));
		chk("pin", 32'(px), 32'(pin));
	endtask
	task s_reset;
		for (int n = 0; n < 6; n++) begin
			rd(8'(8 * n), 0);
			rd(8'(8 * n + 4), 0);
		end
	endtask
	task s_pair;
		for (int n = 0; n < 6; n++) begin
			apb(1, 8'(8 * n), 32'hA0 + 32'(n));
			rd(8'(8 * n), 0);
			apb(1, 8'(8 * n + 4), 32'h50 + 32'(n));
			rd(8'(8 * n), 32'hA0 + 32'(n));
			rd(8'(8 * n + 4), 32'h50 + 32'(n));
		end
	endtask
	task s_shared;
		apb(1, 8'h00, 32'h12);
		apb(1, 8'h34, 32'h34);
		@(posedge clk_sys);
		chk("countLoad", 2'b01, cl);
		chk("countLoadValue", 16'h1234, clv);
		rd(8'h00, 32'hA0);
		t3 <= 16'h9A5B;
		rd(8'h3C, 32'h5B);
		apb(1, 8'h2C, 32'h77);
		rd(8'h28, 32'h9A);
	endtask
	task s_match;
		logic [3:0] px;
		px = 4'b0110;
		apb(1, 8'h44, 32'h3F);
		apb(1, 8'h48, 32'h1);
		t1 <= 16'hA050;
		tk(0, 6'h00, 6'h00);
		tk(0, 6'h01, 6'h01);
		apb(1, 8'h40, 32'h1);
		t3 <= 16'hA353;
		tk(1, 6'h08, 6'h01);
		for (int m = 0; m < 4; m++) begin
			apb(1, 8'h48, 32'((m + 2) % 4));
			tk(0, 6'h09, {5'h00, px[m]});
		end
	endtask
	task s_block;
		apb(1, 8'h40, 32'h09);
		apb(1, 8'h30, 32'h00);
		apb(1, 8'h34, 32'h00);
		// Tick in the cycle right after the counter write
		tick[0] <= 1'b1;
		@(posedge clk_sys);
		tick <= 2'b00;
		repeat (3) @(posedge clk_sys);
		chk("blocked flag", 32'h0, 32'(flg));
		chk("blocked pin", 32'h0, 32'(pin));
		tk(0, 6'h01, 6'h01);
		apb(1, 8'h44, 32'h3E);
		repeat (2) @(posedge clk_sys);
		chk("masked irq", 32'h0, 32'(irq));
		chk("kept flag", 32'h1, 32'(flg));
	endtask
	task s_err;
		apb(1, 8'h80, 32'hFF);
		chk("pslverr", 1, 32'(e));
		rd(8'h80, 0);
		chk("pslverr", 1, 32'(e));
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 0;
		s_reset;
		s_pair;
		s_shared;
		s_match;
		s_block;
		s_err;
		end_sim;
	end
endmodule
